// >>> hdl/pms_regs.v
`timescale 1ns/100ps
`include "pms_map.vh"
// Management registers of two copper ports behind a serial MDC/MDIO slave.
module pms_regs (
  input wire mclk,
  input wire rst,
  input wire mdc,
  input wire mdio_in,
  output wire mdio_out,
  output wire mdio_oe,
  input wire [1:0] link_up,
  input wire [1:0] an_done,
  input wire [1:0] far_fault,
  input wire [1:0] an_restart,
  input wire [1:0] lp_page_vld,
  input wire [31:0] lp_page,
  output wire [1:0] fef_disable,
  output wire [1:0] tx_disable,
  output wire [1:0] led_disable,
  output wire [1:0] adv_pause,
  output wire [7:0] adv_ability
);

  ////////////////////////////////////////////////////////////////////////
  localparam S_PRE = 3'd0;
  localparam S_ST = 3'd1;
  localparam S_HDR = 3'd2;
  localparam S_TA = 3'd3;
  localparam S_DATA = 3'd4;

  function port_hit;
    input [4:0] addr;
    begin
      port_hit = (addr == `PMS_PORT0_ADDR) || (addr == `PMS_PORT1_ADDR);
    end
  endfunction

  function is_reg;
    input [4:0] idx;
    input [4:0] want;
    begin
      is_reg = (idx == want);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling. Edges come from the second stage only.
  wire [1:0] pin_s;
  wire mdc_s;
  wire bit_s;
  reg mdc_d1_q;
  wire mdc_rise;

  pms_sync #(.W(2)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d({mdc, mdio_in}),
    .q(pin_s)
  );

  assign mdc_s = pin_s[1];
  assign bit_s = pin_s[0];
  assign mdc_rise = mdc_s && !mdc_d1_q;

  ////////////////////////////////////////////////////////////////////////
  // Frame engine state.
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [5:0] ones_q;
  reg [5:0] ones_d;
  reg [3:0] cnt_q;
  reg [3:0] cnt_d;
  reg [11:0] hdr_q;
  reg [11:0] hdr_d;
  reg [15:0] shift_q;
  reg [15:0] shift_d;
  reg rd_op_q;
  reg rd_op_d;
  reg port_q;
  reg port_d;
  reg [4:0] register_index_q;
  reg [4:0] register_index_d;
  reg mdio_out_q;
  reg mdio_out_d;
  reg mdio_oe_q;
  reg mdio_oe_d;
  reg [15:0] rd_word;

  wire [11:0] hdr_next;
  wire [15:0] wr_word;
  wire wr_go;

  assign hdr_next = {hdr_q[10:0], bit_s};
  assign wr_word = {shift_q[14:0], bit_s};
  assign wr_go = mdc_rise && (state_q == S_DATA) &&
                 (cnt_q == `PMS_DATA_LAST) && !rd_op_q;

  ////////////////////////////////////////////////////////////////////////
  // Per-port register state.
  wire [5:0] ctrl_w;
  wire [1:0] sts_and_w;
  wire [1:0] sts_fef_w;
  wire [1:0] sts_link_w;
  wire [9:0] adv_w;
  wire [9:0] lpa_w;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_port
      reg [2:0] ctrl_q;
      reg [4:0] adv_q;
      reg and_q;
      reg fef_q;
      reg link_q;
      wire wr_here;

      assign wr_here = wr_go && (port_q == gi);

      always @(posedge mclk) begin
        if (rst) begin
          ctrl_q <= `PMS_CTRL_RST;
          adv_q <= `PMS_ADV_RST;
          and_q <= 1'b0;
          fef_q <= 1'b0;
          link_q <= 1'b0;
        end else begin
          // Writes to any other index leave the port untouched.
          if (wr_here && is_reg(register_index_q, `PMS_REG_CTRL)) begin
            ctrl_q <= {wr_word[`PMS_CTRL_FEF], wr_word[`PMS_CTRL_TXD],
                       wr_word[`PMS_CTRL_LED]};
          end
          if (wr_here && is_reg(register_index_q, `PMS_REG_ADV)) begin
            adv_q <= {wr_word[`PMS_ABL_PAUSE],
                      wr_word[`PMS_ABL_HI:`PMS_ABL_LO]};
          end
          and_q <= an_done[gi];
          // With detection disabled a far end fault is not reported.
          fef_q <= far_fault[gi] && !ctrl_q[`PMS_CTRL_FEF];
          link_q <= link_up[gi];
        end
      end

      pms_partner u_partner (
        .mclk(mclk),
        .rst(rst),
        .page_vld(lp_page_vld[gi]),
        .page(lp_page[gi*16+15:gi*16]),
        .an_restart(an_restart[gi]),
        .link_up(link_up[gi]),
        .ability(lpa_w[gi*5+4:gi*5])
      );

      assign ctrl_w[gi*3+2:gi*3] = ctrl_q;
      assign adv_w[gi*5+4:gi*5] = adv_q;
      assign sts_and_w[gi] = and_q;
      assign sts_fef_w[gi] = fef_q;
      assign sts_link_w[gi] = link_q;
      assign fef_disable[gi] = ctrl_q[`PMS_CTRL_FEF];
      assign tx_disable[gi] = ctrl_q[`PMS_CTRL_TXD];
      assign led_disable[gi] = ctrl_q[`PMS_CTRL_LED];
      assign adv_pause[gi] = adv_q[4];
      assign adv_ability[gi*4+3:gi*4] = adv_q[3:0];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read word for the index just received. Port comes from address bit 0.
  wire rp;
  assign rp = hdr_next[`PMS_F_PORT];

  always @* begin
    rd_word = `PMS_ZERO16;
    case (hdr_next[`PMS_F_REG])
      `PMS_REG_CTRL: begin
        rd_word[`PMS_CTRL_FEF] = ctrl_w[rp*3+2];
        rd_word[`PMS_CTRL_TXD] = ctrl_w[rp*3+1];
        rd_word[`PMS_CTRL_LED] = ctrl_w[rp*3];
      end
      `PMS_REG_STS: begin
        rd_word = `PMS_STS_FIXED;
        rd_word[`PMS_STS_AND] = sts_and_w[rp];
        rd_word[`PMS_STS_FEF] = sts_fef_w[rp];
        rd_word[`PMS_STS_LINK] = sts_link_w[rp];
      end
      `PMS_REG_IDH: begin
        rd_word = `PMS_ID_HIGH;
      end
      `PMS_REG_IDL: begin
        rd_word = `PMS_ID_LOW;
      end
      `PMS_REG_ADV: begin
        rd_word[4:0] = `PMS_SELECTOR;
        rd_word[`PMS_ABL_PAUSE] = adv_w[rp*5+4];
        rd_word[`PMS_ABL_HI:`PMS_ABL_LO] = adv_w[rp*5+3 -: 4];
      end
      `PMS_REG_LPA: begin
        rd_word[4:0] = `PMS_SELECTOR;
        rd_word[`PMS_ABL_PAUSE] = lpa_w[rp*5+4];
        rd_word[`PMS_ABL_HI:`PMS_ABL_LO] = lpa_w[rp*5+3 -: 4];
      end
      `PMS_REG_RSVD: begin
        rd_word = `PMS_ZERO16;
      end
      default: begin
        rd_word = `PMS_ZERO16;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencing, one step per sampled rising edge of mdc. The port
  // only drives mdio from the second turnaround bit to the last data bit.
  always @* begin
    state_d = state_q;
    ones_d = ones_q;
    cnt_d = cnt_q;
    hdr_d = hdr_q;
    shift_d = shift_q;
    rd_op_d = rd_op_q;
    port_d = port_q;
    register_index_d = register_index_q;
    mdio_out_d = mdio_out_q;
    mdio_oe_d = mdio_oe_q;
    if (mdc_rise) begin
      case (state_q)
        S_PRE: begin
          if (bit_s) begin
            if (ones_q != `PMS_ONES_MIN) begin
              ones_d = ones_q + 6'd1;
            end
          end else begin
            // A full preamble is needed; it cannot be suppressed.
            if (ones_q == `PMS_ONES_MIN) begin
              state_d = S_ST;
            end
            ones_d = 6'd0;
          end
        end
        S_ST: begin
          cnt_d = 4'd0;
          state_d = bit_s ? S_HDR : S_PRE;
        end
        S_HDR: begin
          hdr_d = hdr_next;
          if (cnt_q == `PMS_HDR_LAST) begin
            cnt_d = 4'd0;
            rd_op_d = (hdr_next[`PMS_F_OP] == `PMS_OP_RD);
            port_d = hdr_next[`PMS_F_PORT];
            register_index_d = hdr_next[`PMS_F_REG];
            shift_d = rd_word;
            if (port_hit(hdr_next[`PMS_F_PHY]) &&
                ((hdr_next[`PMS_F_OP] == `PMS_OP_RD) ||
                 (hdr_next[`PMS_F_OP] == `PMS_OP_WR))) begin
              state_d = S_TA;
            end else begin
              state_d = S_PRE;
            end
          end else begin
            cnt_d = cnt_q + 4'd1;
          end
        end
        S_TA: begin
          if (cnt_q == `PMS_TA_LAST) begin
            cnt_d = 4'd0;
            state_d = S_DATA;
            if (rd_op_q) begin
              mdio_out_d = shift_q[15];
              shift_d = {shift_q[14:0], 1'b0};
            end
          end else begin
            cnt_d = cnt_q + 4'd1;
            if (rd_op_q) begin
              mdio_out_d = 1'b0;
              mdio_oe_d = 1'b1;
            end
          end
        end
        S_DATA: begin
          if (cnt_q == `PMS_DATA_LAST) begin
            cnt_d = 4'd0;
            mdio_oe_d = 1'b0;
            mdio_out_d = 1'b0;
            state_d = S_PRE;
          end else begin
            cnt_d = cnt_q + 4'd1;
            if (rd_op_q) begin
              mdio_out_d = shift_q[15];
              shift_d = {shift_q[14:0], 1'b0};
            end else begin
              shift_d = wr_word;
            end
          end
        end
        default: begin
          state_d = S_PRE;
          ones_d = 6'd0;
          mdio_oe_d = 1'b0;
        end
      endcase
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      mdc_d1_q <= 1'b0;
      state_q <= S_PRE;
      ones_q <= 6'd0;
      cnt_q <= 4'd0;
      hdr_q <= 12'h000;
      shift_q <= `PMS_ZERO16;
      rd_op_q <= 1'b0;
      port_q <= 1'b0;
      register_index_q <= 5'h00;
      mdio_out_q <= 1'b0;
      mdio_oe_q <= 1'b0;
    end else begin
      mdc_d1_q <= mdc_s;
      state_q <= state_d;
      ones_q <= ones_d;
      cnt_q <= cnt_d;
      hdr_q <= hdr_d;
      shift_q <= shift_d;
      rd_op_q <= rd_op_d;
      port_q <= port_d;
      register_index_q <= register_index_d;
      mdio_out_q <= mdio_out_d;
      mdio_oe_q <= mdio_oe_d;
    end
  end

  assign mdio_out = mdio_out_q;
  assign mdio_oe = mdio_oe_q;

endmodule // pms_regs

// >>> hdl/pms_map.vh
// Notes on behaviour
// - Control bits 2..0 disable fault, transmit, LED.
// - Status bit 15 always reads zero.
// - Status bits 14..11 read one, speed abilities.
// - Status bits 10..6 read zero, no suppression.
// - Status bit 5 shows negotiation done.
// - Status bit 4 shows far end fault.
// - Status bit 3 reads one, negotiation ability.
// - Status bit 2 shows link up.
// - Status bits 1 and 0 read zero.
// - Identifier high is a constant word.
// - Identifier low is a constant word.
// - Advertisement bit 10 pause, writable, resets one.
// - Advertisement bits 8..5 writable, reset one.
// - Advertisement bits 15..11 and 9 read zero.
// - Partner bit 10 shows partner pause ability.
// - Partner bits 8..5 show partner abilities.
// - Ports answer at addresses 2 and 3.
`ifndef PMS_MAP_VH
`define PMS_MAP_VH

`define PMS_PORT0_ADDR 5'h02
`define PMS_PORT1_ADDR 5'h03

`define PMS_REG_CTRL 5'h00
`define PMS_REG_STS 5'h01
`define PMS_REG_IDH 5'h02
`define PMS_REG_IDL 5'h03
`define PMS_REG_ADV 5'h04
`define PMS_REG_LPA 5'h05
`define PMS_REG_RSVD 5'h1d
`define PMS_REG_SPEC 5'h1f

// Identification words; the values are arbitrary.
`define PMS_ID_HIGH 16'h0a5a
`define PMS_ID_LOW 16'h5c31

`define PMS_CTRL_FEF 2
`define PMS_CTRL_TXD 1
`define PMS_CTRL_LED 0
`define PMS_CTRL_RST 3'h0

`define PMS_STS_FIXED 16'h7808
`define PMS_STS_AND 5
`define PMS_STS_FEF 4
`define PMS_STS_LINK 2

`define PMS_ABL_PAUSE 10
`define PMS_ABL_HI 8
`define PMS_ABL_LO 5
`define PMS_ADV_RST 5'h1f
`define PMS_SELECTOR 5'h01
`define PMS_LPA_RST 5'h00

`define PMS_ONES_MIN 6'h20
`define PMS_HDR_LAST 4'hb
`define PMS_TA_LAST 4'h1
`define PMS_DATA_LAST 4'hf
`define PMS_OP_RD 2'h2
`define PMS_OP_WR 2'h1
`define PMS_F_OP 11:10
`define PMS_F_PHY 9:5
`define PMS_F_PORT 5
`define PMS_F_REG 4:0
`define PMS_ZERO16 16'h0000

`endif

// >>> hdl/pms_sync.v
`timescale 1ns/100ps
// Two-stage synchroniser for pins sampled on mclk.
module pms_sync #(
  parameter W = 2
) (
  input wire mclk,
  input wire rst,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  always @(posedge mclk) begin
    if (rst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule // pms_sync

// >>> hdl/pms_partner.v
`timescale 1ns/100ps
`include "pms_map.vh"
// Holds one port's partner abilities: pause in bit 4, then 100FD..10HD.
module pms_partner (
  input wire mclk,
  input wire rst,
  input wire page_vld,
  input wire [15:0] page,
  input wire an_restart,
  input wire link_up,
  output wire [4:0] ability
);
  reg [4:0] abl_q;
  always @(posedge mclk) begin
    if (rst) begin
      abl_q <= `PMS_LPA_RST;
    end else if (an_restart || !link_up) begin
      // A stale page must never survive a restart, so clearing wins.
      abl_q <= `PMS_LPA_RST;
    end else if (page_vld) begin
      abl_q <= {page[`PMS_ABL_PAUSE], page[`PMS_ABL_HI:`PMS_ABL_LO]};
    end
  end
  assign ability = abl_q;
endmodule // pms_partner

// >>> dv/pms_mgr.sv
`timescale 1ns/100ps
module pms_mgr (
  input wire mclk,
  input wire mdio_out,
  input wire mdio_oe,
  output logic mdc,
  output logic mdio_in
);
  logic drv_q = 1'b1;
  logic bit_q = 1'b1;
  // The pull-up wins when neither side drives the wire.
  assign mdio_in = drv_q ? bit_q : (mdio_oe ? mdio_out : 1'b1);
  initial mdc = 1'b0;
  ////////////////////////////////////////
  // Half period of 8 mclk keeps mdc near 1.5 MHz, well inside the limit.
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
    input logic [4:0] idx, input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    f = {32'hffff_ffff, 2'b01, op, phy, idx, 2'b10, wd};
    for (int i = 63; i >= 0; i--) begin
      drv_q = (op == 2'b01) || (i > 17);
      bit_q = f[i];
      repeat (8) @(negedge mclk);
      rd = {rd[14:0], mdio_in};
      mdc = 1'b1;
      repeat (8) @(negedge mclk);
      mdc = 1'b0;
    end
    drv_q = 1'b1;
    bit_q = 1'b1;
    // One idle mclk keeps a following frame from reassigning the pins at once.
    @(negedge mclk);
  endtask
endmodule // pms_mgr

// >>> dv/pms_regs_props.sv
`timescale 1ns/100ps
module pms_regs_props (
  input wire mclk,
  input wire rst,
  input wire mdc,
  input wire mdio_out,
  input wire mdio_oe,
  input wire [1:0] fef_disable,
  input wire [1:0] tx_disable,
  input wire [1:0] led_disable,
  input wire [1:0] adv_pause,
  input wire [7:0] adv_ability
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_turn;
    !mdio_out ##1 mdio_oe [*8];
  endsequence
  property p_ctl_rst;
    $fell(rst) |-> {fef_disable, tx_disable, led_disable} == 6'h00;
  endproperty
  property p_adv_rst;
    $fell(rst) |-> adv_pause == 2'h3 && adv_ability == 8'hff;
  endproperty
  property p_oe_rst;
    $fell(rst) |-> !mdio_oe && !mdio_out;
  endproperty
  property p_turn;
    $rose(mdio_oe) |-> s_turn;
  endproperty
  property p_oe_mdc;
    $rose(mdio_oe) |-> mdc;
  endproperty
  property p_out_mdc;
    $changed(mdio_out) |-> mdc;
  endproperty
  property p_ctl_quiet;
    $changed({fef_disable, tx_disable, led_disable}) |-> mdc && !mdio_oe;
  endproperty
  property p_adv_quiet;
    $changed({adv_pause, adv_ability}) |-> mdc && !mdio_oe;
  endproperty
  // Reset checks look at the first edge after release only.
  a_ctl_rst: assert property (p_ctl_rst)
    else $error("control bits not cleared");
  a_adv_rst: assert property (p_adv_rst)
    else $error("advertisement not set");
  a_oe_rst: assert property (p_oe_rst)
    else $error("data pin driven after reset");
  a_turn: assert property (p_turn)
    else $error("bad turnaround");
  a_oe_mdc: assert property (p_oe_mdc)
    else $error("drive starts off clock high");
  a_out_mdc: assert property (p_out_mdc)
    else $error("data changes off clock high");
  a_ctl_quiet: assert property (p_ctl_quiet)
    else $error("control changed outside write");
  a_adv_quiet: assert property (p_adv_quiet)
    else $error("advertisement changed outside write");
endmodule // pms_regs_props
bind pms_regs pms_regs_props u_pms_regs_props (.mclk(mclk), .rst(rst),
  .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
  .fef_disable(fef_disable), .tx_disable(tx_disable),
  .led_disable(led_disable), .adv_pause(adv_pause),
  .adv_ability(adv_ability));

// >>> dv/tb_top.sv
`timescale 1ns/100ps
`include "pms_map.vh"
module tb_top;
  typedef struct {logic [4:0] p; logic [4:0] i; logic [15:0] e;} pms_row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] link_up = 2'b01, an_done = 2'b01, far_fault = 2'b01;
  logic [1:0] an_restart = 2'b00, lp_page_vld = 2'b00;
  logic [31:0] lp_page = 32'h0000_0000;
  wire mdc, mdio_in, mdio_out, mdio_oe;
  wire [1:0] fef_disable, tx_disable, led_disable, adv_pause;
  wire [7:0] adv_ability;
  int err_count = 0;
  int n_tests = 0;
  int n_oe = 0;
  logic [15:0] rd;
  pms_row_t rows[9];
  always #20 mclk = ~mclk;
  always @(posedge mdio_oe) n_oe++;
  pms_regs u_pms_regs (.mclk(mclk), .rst(rst), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .link_up(link_up), .an_done(an_done), .far_fault(far_fault),
    .an_restart(an_restart), .lp_page_vld(lp_page_vld),
    .lp_page(lp_page), .fef_disable(fef_disable),
    .tx_disable(tx_disable), .led_disable(led_disable),
    .adv_pause(adv_pause), .adv_ability(adv_ability));
  pms_mgr u_pms_mgr (.mclk(mclk), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .mdc(mdc), .mdio_in(mdio_in));
  ////////////////////////////////////////
  task check(input string n, input logic [15:0] got, input logic [15:0] e);
    n_tests++;
    if (got !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, got);
    end
  endtask
  task rc(input logic [4:0] p, input logic [4:0] i, input logic [15:0] e);
    u_pms_mgr.xfer(2'b10, p, i, 16'h0000, rd);
    check("read data", rd, e);
  endtask
  // Outputs settle a few mclk after the last rise of a write.
  task wr(input logic [4:0] p, input logic [4:0] i, input logic [15:0] d);
    u_pms_mgr.xfer(2'b01, p, i, d, rd);
    repeat (4) @(negedge mclk);
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #2_500_000;
    err_count++;
    wrap_up();
  end
  ////////////////////////////////////////
  initial begin
    rows = '{'{2, 0, 16'h0000}, '{2, 1, 16'h783c}, '{3, 1, 16'h7808},
      '{2, 2, `PMS_ID_HIGH}, '{3, 3, `PMS_ID_LOW}, '{2, 4, 16'h05e1},
      '{2, 5, 16'h0001}, '{2, 5'h1d, 16'h0000}, '{3, 5'h1f, 16'h0000}};
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    foreach (rows[k]) begin
      pms_row_t w;
      w = rows[k];
      rc(w.p, w.i, w.e);
    end
    $display("table test done");
    wr(2, 0, 16'hffff);
    check("ctl", 16'({fef_disable, tx_disable, led_disable}), 16'h0015);
    rc(2, 0, 16'h0007);
    rc(2, 1, 16'h782c);
    wr(2, 0, 16'h0000);
    wr(3, 4, 16'h0000);
    check("adv", 16'({adv_pause, adv_ability}), 16'h010f);
    rc(3, 4, 16'h0001);
    wr(3, 4, 16'hffff);
    rc(3, 4, 16'h05e1);
    wr(2, 1, 16'h0000);
    wr(2, 5'h1d, 16'hffff);
    rc(2, 1, 16'h783c);
    rc(2, 5'h1d, 16'h0000);
    $display("write test done");
    lp_page = 32'h0000_ffff;
    lp_page_vld = 2'b01;
    @(negedge mclk);
    lp_page_vld = 2'b00;
    rc(2, 5, 16'h05e1);
    rc(3, 5, 16'h0001);
    an_restart = 2'b01;
    repeat (2) @(negedge mclk);
    an_restart = 2'b00;
    rc(2, 5, 16'h0001);
    lp_page_vld = 2'b01;
    @(negedge mclk);
    lp_page_vld = 2'b00;
    link_up = 2'b00;
    rc(2, 5, 16'h0001);
    rc(2, 1, 16'h7838);
    link_up = 2'b01;
    $display("partner test done");
    n_oe = 0;
    u_pms_mgr.xfer(2'b10, 5'h04, 5'h01, 16'h0000, rd);
    u_pms_mgr.xfer(2'b11, 5'h02, 5'h01, 16'h0000, rd);
    check("refused", 16'(n_oe), 16'h0000);
    rc(3, 2, `PMS_ID_HIGH);
    $display("refusal test done");
    wr(2, 0, 16'h0007);
    wr(2, 4, 16'h0000);
    rst = 1'b1;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    check("ctl", 16'({fef_disable, tx_disable, led_disable}), 16'h0000);
    check("adv", 16'({adv_pause, adv_ability}), 16'h03ff);
    $display("reset test done");
    wrap_up();
  end
endmodule // tb_top
